// >>> logic/oscdz_pkg.sv
// Package with the register map, field layout, codes and helpers of the clock control block.
`default_nettype none
package oscdz_pkg;
  // Register offsets on the software port.
  localparam logic [3:0] OFS_OSC  = 4'h0;
  localparam logic [3:0] OFS_DIV  = 4'h1;
  localparam logic [3:0] OFS_UNLK = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  localparam logic [3:0] OFS_IEN  = 4'h4;
  localparam logic [3:0] OFS_ICLR = 4'h5;
  // Oscillator control field positions.
  localparam int OSC_SWREQ = 0;
  localparam int OSC_CF    = 3;
  localparam int OSC_NEW   = 8;
  localparam int OSC_CUR   = 12;
  // Clock divisor field positions.
  localparam int DIV_ROI   = 15;
  localparam int DIV_DOZE  = 12;
  localparam int DIV_REDUCTION_ENABLE = 11;
  localparam int DIV_FRC   = 8;
  localparam int DIV_POST  = 6;
  localparam int DIV_PRE   = 0;
  // Values after reset.
  localparam logic [15:0] DIV_RST = 16'h3040;
  localparam logic [2:0]  SRC_RST = 3'h0;
  // Unlock keys; the values are arbitrary.
  localparam logic [15:0] UNLK_KEY1 = 16'h00c3;
  localparam logic [15:0] UNLK_KEY2 = 16'h003c;
  // Interrupt status bits.
  localparam int IRQ_CF = 0;
  localparam int IRQ_SW = 1;
  localparam int IRQ_W  = 2;
  // Oscillator source codes.
  typedef enum logic [2:0] {
    SRC_FRC     = 3'h0,
    SRC_FRC_PLL = 3'h1,
    SRC_PRI     = 3'h2,
    SRC_PRI_PLL = 3'h3,
    SRC_RSVD    = 3'h4,
    SRC_LOW_POWER_RC    = 3'h5,
    SRC_FRC16   = 3'h6,
    SRC_FRC_DIV = 3'h7
  } oscdz_src_t;
  // Unlock sequencer states.
  typedef enum logic [2:0] {
    LK_LOCKED = 3'h1,
    LK_KEY1   = 3'h2,
    LK_OPEN   = 3'h4
  } oscdz_lock_t;
  // Clock switch states.
  typedef enum logic [1:0] {
    SW_IDLE = 2'h1,
    SW_WAIT = 2'h2
  } oscdz_sw_t;
  // Divide ratio of a three-bit code; the RC postscaler jumps to 256 at its top code.
  function automatic logic [8:0] oscdz_ratio(input logic [2:0] code, input logic rc);
    oscdz_ratio = (rc && code == 3'h7) ? 9'h100 : 9'(9'h001 << code);
  endfunction : oscdz_ratio
endpackage : oscdz_pkg
`default_nettype wire

// >>> logic/oscdz_sync.sv
// Three-stage input synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module oscdz_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  // Asynchronous inputs and their filtered copy.
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } oscdz_sync_st_t;
  oscdz_sync_st_t st_r;
  oscdz_sync_st_t st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end
  assign sync_out = st_r.q;
endmodule : oscdz_sync
`default_nettype wire

// >>> logic/oscdz_doze.sv
// Processor clock reduction: emits one clock-enable tick every selected number of cycles.
`timescale 1ns/1ps
`default_nettype none
module oscdz_doze #(
  parameter int CW = 7
) (
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Reduction control.
  input  wire logic       en_in,
  input  wire logic [2:0] code_in,
  // Processor clock enable.
  output var  logic       tick_out
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } oscdz_doze_st_t;
  oscdz_doze_st_t st_r;
  oscdz_doze_st_t st_nxt;
  logic [8:0]     ratio;
  logic [CW-1:0]  limit;
  always_comb begin
    ratio  = oscdz_pkg::oscdz_ratio(code_in, 1'b0);
    limit  = CW'(ratio - 9'h001);
    st_nxt = st_r;
    if (!en_in || st_r.cnt >= limit) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt  = st_r.cnt + 1'b1;
      st_nxt.tick = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end
  assign tick_out = st_r.tick;
endmodule : oscdz_doze
`default_nettype wire

// >>> logic/oscdz_top.sv
// Oscillator switch, clock-fail flag and processor clock reduction control with its registers.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module oscdz_top #(
  parameter int DOZE_CW = 7
) (
  // Clock, reset and clock enable.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Register port.
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output var  logic [15:0] rd_data_out,
  // Clock-fail monitor and oscillator mux handshake.
  input  wire logic        clock_fail_in,
  input  wire logic        osc_ready_in,
  output var  logic [2:0]  osc_target_out,
  output var  logic        osc_switching_out,
  output var  logic [2:0]  current_source_out,
  // Interrupt side.
  input  wire logic        irq_event_in,
  output var  logic        trap_out,
  output var  logic        irq_out,
  // Clock settings towards the clock tree.
  output var  logic        cpu_clk_en_out,
  output var  logic [8:0]  rc_div_ratio_out,
  output var  logic [1:0]  pll_output_divider_out,
  output var  logic [4:0]  pll_input_divider_out
);
  typedef struct packed {
    logic [2:0]                new_source_select;
    logic [2:0]                current_source;
    logic                      switch_request;
    logic                      clock_fail_flag;
    oscdz_pkg::oscdz_lock_t    lock;
    oscdz_pkg::oscdz_sw_t      sw;
    logic [2:0]                target;
    logic                      recover_on_interrupt;
    logic [2:0]                cpu_clock_reduction;
    logic                      reduction_enable;
    logic [2:0]                rc_postscaler;
    logic [1:0]                pll_output_divider;
    logic [4:0]                pll_input_divider;
    logic [oscdz_pkg::IRQ_W-1:0] stat;
    logic [oscdz_pkg::IRQ_W-1:0] ien;
    logic [15:0]               rd;
    logic                      trap;
    logic                      irq;
    logic [8:0]                rc_ratio;
  } oscdz_st_t;

  oscdz_st_t   st_r;
  oscdz_st_t   st_nxt;
  logic [1:0]  pins_s;
  logic        fail_s;
  logic        ready_s;
  logic        wr_osc;
  logic        wr_div;
  logic        osc_open;
  logic [oscdz_pkg::IRQ_W-1:0] ev;
  logic [15:0] osc_word;
  logic [15:0] div_word;
  logic [2:0]  wr_doze;

  oscdz_sync #(
    .W (2)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   ({osc_ready_in, clock_fail_in}),
    .sync_out   (pins_s)
  );

  oscdz_doze #(
    .CW (DOZE_CW)
  ) u_doze (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .en_in      (st_r.reduction_enable),
    .code_in    (st_r.cpu_clock_reduction),
    .tick_out   (cpu_clk_en_out)
  );

  assign fail_s  = pins_s[0];
  assign ready_s = pins_s[1];

  // Unmapped bits are built as constant zero so reads of them can never leak state.
  assign osc_word = {1'b0, st_r.current_source, 1'b0, st_r.new_source_select,
                     4'h0, st_r.clock_fail_flag, 2'h0, st_r.switch_request};
  assign div_word = {st_r.recover_on_interrupt, st_r.cpu_clock_reduction,
                     st_r.reduction_enable, st_r.rc_postscaler,
                     st_r.pll_output_divider, 1'b0, st_r.pll_input_divider};

  always_comb begin
    wr_osc   = wr_en_in && addr_in == oscdz_pkg::OFS_OSC;
    wr_div   = wr_en_in && addr_in == oscdz_pkg::OFS_DIV;
    osc_open = st_r.lock == oscdz_pkg::LK_OPEN;
    wr_doze  = wr_data_in[oscdz_pkg::DIV_DOZE +: 3];
    ev       = '0;
    st_nxt   = st_r;
    st_nxt.trap = 1'b0;

    // Unlock sequencer: the open state is spent by any following write.
    case (st_r.lock)
      oscdz_pkg::LK_LOCKED: begin
        if (wr_en_in && addr_in == oscdz_pkg::OFS_UNLK &&
            wr_data_in == oscdz_pkg::UNLK_KEY1) begin
          st_nxt.lock = oscdz_pkg::LK_KEY1;
        end
      end
      oscdz_pkg::LK_KEY1: begin
        if (wr_en_in) begin
          if (addr_in == oscdz_pkg::OFS_UNLK && wr_data_in == oscdz_pkg::UNLK_KEY2) begin
            st_nxt.lock = oscdz_pkg::LK_OPEN;
          end else begin
            st_nxt.lock = oscdz_pkg::LK_LOCKED;
          end
        end
      end
      oscdz_pkg::LK_OPEN: begin
        if (wr_en_in) begin
          st_nxt.lock = oscdz_pkg::LK_LOCKED;
        end
      end
      default: begin
        st_nxt.lock = oscdz_pkg::LK_LOCKED;
      end
    endcase

    // Oscillator control write, honoured only while unlocked.
    if (wr_osc && osc_open) begin
      st_nxt.new_source_select = wr_data_in[oscdz_pkg::OSC_NEW +: 3];
      st_nxt.clock_fail_flag   = wr_data_in[oscdz_pkg::OSC_CF];
      if (wr_data_in[oscdz_pkg::OSC_SWREQ]) begin
        st_nxt.switch_request = 1'b1;
      end
    end
    // The monitor wins over a software clear in the same cycle.
    if (fail_s) begin
      st_nxt.clock_fail_flag = 1'b1;
    end
    if (st_nxt.clock_fail_flag && !st_r.clock_fail_flag) begin
      st_nxt.trap = 1'b1;
      ev[oscdz_pkg::IRQ_CF] = 1'b1;
    end

    // Clock switch sequencer.
    case (st_r.sw)
      oscdz_pkg::SW_IDLE: begin
        if (st_r.switch_request) begin
          if (st_r.new_source_select == oscdz_pkg::SRC_RSVD) begin
            // A reserved code cannot be built, so the request ends with no change.
            st_nxt.switch_request = 1'b0;
            ev[oscdz_pkg::IRQ_SW] = 1'b1;
          end else begin
            st_nxt.target = st_r.new_source_select;
            st_nxt.sw     = oscdz_pkg::SW_WAIT;
          end
        end
      end
      oscdz_pkg::SW_WAIT: begin
        if (ready_s) begin
          st_nxt.current_source = st_r.target;
          st_nxt.switch_request = 1'b0;
          st_nxt.sw             = oscdz_pkg::SW_IDLE;
          ev[oscdz_pkg::IRQ_SW] = 1'b1;
        end
      end
      default: begin
        st_nxt.sw = oscdz_pkg::SW_IDLE;
      end
    endcase

    // Clock divisor write; the divisor needs no unlock.
    if (wr_div) begin
      st_nxt.recover_on_interrupt = wr_data_in[oscdz_pkg::DIV_ROI];
      st_nxt.cpu_clock_reduction  = wr_doze;
      st_nxt.reduction_enable     = wr_data_in[oscdz_pkg::DIV_REDUCTION_ENABLE] &&
                                    wr_doze != 3'h0;
      st_nxt.rc_postscaler        = wr_data_in[oscdz_pkg::DIV_FRC +: 3];
      st_nxt.pll_output_divider   = wr_data_in[oscdz_pkg::DIV_POST +: 2];
      st_nxt.pll_input_divider    = wr_data_in[oscdz_pkg::DIV_PRE +: 5];
    end
    // An interrupt overrides a software set in the same cycle.
    if (irq_event_in && st_r.recover_on_interrupt) begin
      st_nxt.reduction_enable = 1'b0;
    end
    st_nxt.rc_ratio = oscdz_pkg::oscdz_ratio(st_nxt.rc_postscaler, 1'b1);

    // Interrupt status: set beats clear.
    if (wr_en_in && addr_in == oscdz_pkg::OFS_ICLR) begin
      st_nxt.stat = st_r.stat & ~wr_data_in[oscdz_pkg::IRQ_W-1:0];
    end
    if (wr_en_in && addr_in == oscdz_pkg::OFS_IEN) begin
      st_nxt.ien = wr_data_in[oscdz_pkg::IRQ_W-1:0];
    end
    st_nxt.stat = st_nxt.stat | ev;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.ien);

    // Read port: data stand for one cycle only.
    st_nxt.rd = 16'h0000;
    if (rd_en_in) begin
      if (addr_in == oscdz_pkg::OFS_OSC) begin
        st_nxt.rd = osc_word;
      end else if (addr_in == oscdz_pkg::OFS_DIV) begin
        st_nxt.rd = div_word;
      end else if (addr_in == oscdz_pkg::OFS_STAT) begin
        st_nxt.rd = 16'(st_r.stat);
      end else if (addr_in == oscdz_pkg::OFS_IEN) begin
        st_nxt.rd = 16'(st_r.ien);
      end else begin
        st_nxt.rd = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r                      <= '0;
      st_r.new_source_select    <= oscdz_pkg::SRC_RST;
      st_r.current_source       <= oscdz_pkg::SRC_RST;
      st_r.lock                 <= oscdz_pkg::LK_LOCKED;
      st_r.sw                   <= oscdz_pkg::SW_IDLE;
      st_r.recover_on_interrupt <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_ROI];
      st_r.cpu_clock_reduction  <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_DOZE +: 3];
      st_r.reduction_enable     <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_REDUCTION_ENABLE];
      st_r.rc_postscaler        <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_FRC +: 3];
      st_r.pll_output_divider   <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_POST +: 2];
      st_r.pll_input_divider    <= oscdz_pkg::DIV_RST[oscdz_pkg::DIV_PRE +: 5];
      st_r.rc_ratio             <= 9'h001;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_out            = st_r.rd;
  assign osc_target_out         = st_r.target;
  // The wait state is one-hot, so its own bit drives the output straight from the flop.
  assign osc_switching_out      = st_r.sw[1];
  assign current_source_out     = st_r.current_source;
  assign trap_out               = st_r.trap;
  assign irq_out                = st_r.irq;
  assign rc_div_ratio_out       = st_r.rc_ratio;
  assign pll_output_divider_out = st_r.pll_output_divider;
  assign pll_input_divider_out  = st_r.pll_input_divider;

  property p_fail_sets;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && fail_s |=> st_r.clock_fail_flag;
  endproperty
  a_fail_sets: assert property (p_fail_sets)
    else $error("clock fail flag not set by monitor");

  property p_sw_cf;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && wr_osc && osc_open && wr_data_in[3] && !st_r.clock_fail_flag
      |=> st_r.clock_fail_flag && trap_out;
  endproperty
  a_sw_cf: assert property (p_sw_cf)
    else $error("software set of clock fail flag did not trap");

  property p_trap_edge;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      trap_out |-> st_r.clock_fail_flag && !$past(st_r.clock_fail_flag);
  endproperty
  a_trap_edge: assert property (p_trap_edge)
    else $error("trap without a rising clock fail flag");

  property p_switch_done;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && osc_switching_out && ready_s |=>
        !st_r.switch_request && st_r.current_source == $past(st_r.target);
  endproperty
  a_switch_done: assert property (p_switch_done)
    else $error("switch did not complete on ready");

  property p_locked;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && wr_osc && !osc_open |=> $stable(st_r.new_source_select);
  endproperty
  a_locked: assert property (p_locked)
    else $error("oscillator control written while locked");

  property p_roi;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && irq_event_in && st_r.recover_on_interrupt |=> !st_r.reduction_enable;
  endproperty
  a_roi: assert property (p_roi)
    else $error("interrupt did not clear reduction enable");

  property p_no_roi;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && irq_event_in && !st_r.recover_on_interrupt && !wr_div
      |=> $stable(st_r.reduction_enable);
  endproperty
  a_no_roi: assert property (p_no_roi)
    else $error("interrupt changed reduction enable");

  property p_doze_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      st_r.cpu_clock_reduction == 3'h0 |-> !st_r.reduction_enable;
  endproperty
  a_doze_zero: assert property (p_doze_zero)
    else $error("reduction enabled with code zero");

  property p_unimpl;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && rd_en_in && addr_in == oscdz_pkg::OFS_OSC |=> rd_data_out[4:1] == 4'h0 ||
        rd_data_out[4:1] == 4'h4;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented oscillator bits read nonzero");

  property p_rc_top;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ce_in && st_nxt.rc_postscaler == 3'h7 |=> rc_div_ratio_out == 9'h100;
  endproperty
  a_rc_top: assert property (p_rc_top)
    else $error("rc postscaler top code not 256");

  property p_no_rsvd;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      current_source_out != oscdz_pkg::SRC_RSVD;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd)
    else $error("current source holds reserved code");
endmodule : oscdz_top
`default_nettype wire

// >>> sim/oscdz_top_bench.sv
// Self-checking testbench for the oscillator switch and clock reduction block.
`timescale 1ns/1ps
`default_nettype none
module oscdz_top_bench;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic        clock_fail_in = 1'b0;
  logic        osc_ready_in = 1'b0;
  logic        irq_event_in = 1'b0;
  logic [15:0] rd_data_out;
  logic [2:0]  osc_target_out;
  logic        osc_switching_out;
  logic [2:0]  current_source_out;
  logic        trap_out;
  logic        irq_out;
  logic        cpu_clk_en_out;
  logic [8:0]  rc_div_ratio_out;
  logic [1:0]  pll_output_divider_out;
  logic [4:0]  pll_input_divider_out;
  int          fail_count = 0;
  int          num_checks = 0;
  int          trap_cnt = 0;
  int          tick_cnt = 0;
  logic        ce_in = 1'b1;
  logic [2:0]  cur = 3'h0;

  oscdz_top #(.DOZE_CW(7)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .clock_fail_in(clock_fail_in), .osc_ready_in(osc_ready_in),
    .osc_target_out(osc_target_out), .osc_switching_out(osc_switching_out),
    .current_source_out(current_source_out), .irq_event_in(irq_event_in),
    .trap_out(trap_out), .irq_out(irq_out), .cpu_clk_en_out(cpu_clk_en_out),
    .rc_div_ratio_out(rc_div_ratio_out), .pll_output_divider_out(pll_output_divider_out),
    .pll_input_divider_out(pll_input_divider_out));

  always #4 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    if (trap_out === 1'b1) trap_cnt++;
    if (cpu_clk_en_out === 1'b1) tick_cnt++;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_in   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1 d = rd_data_out;
  endtask : rd

  // Software must unlock before every oscillator control write.
  task automatic wr_osc(input logic [15:0] d);
    wr(oscdz_pkg::OFS_UNLK, oscdz_pkg::UNLK_KEY1);
    wr(oscdz_pkg::OFS_UNLK, oscdz_pkg::UNLK_KEY2);
    wr(oscdz_pkg::OFS_OSC, d);
  endtask : wr_osc

  task automatic test_reset;
    logic [15:0] d;
    rd(oscdz_pkg::OFS_DIV, d);
    check("divisor reset", 16'h3040, d);
    rd(oscdz_pkg::OFS_OSC, d);
    check("osc reset", 16'h0000, d);
    check("rc ratio reset", 16'h0001, 16'(rc_div_ratio_out));
    check("pll out reset", 16'h0001, 16'(pll_output_divider_out));
    check("pll in reset", 16'h0000, 16'(pll_input_divider_out));
    rd(4'hf, d);
    check("unmapped read", 16'h0000, d);
  endtask : test_reset

  task automatic test_lock;
    logic [15:0] d;
    wr(oscdz_pkg::OFS_OSC, 16'h0500);
    rd(oscdz_pkg::OFS_OSC, d);
    check("locked write", 16'h0000, d);
    wr_osc(16'h0516);
    rd(oscdz_pkg::OFS_OSC, d);
    check("unimplemented bits", 16'h0500, d);
  endtask : test_lock

  // Reserved code 100 leaves the current source as it was.
  task automatic do_switch(input logic [2:0] code);
    logic [15:0] d;
    int i;
    wr_osc({5'h00, code, 8'h01});
    if (code != 3'h4) begin
      for (i = 0; i < 10 && osc_switching_out !== 1'b1; i++) @(posedge clk_sys_in);
      check("target", 16'(code), 16'(osc_target_out));
      osc_ready_in <= 1'b1;
      for (i = 0; i < 12 && osc_switching_out !== 1'b0; i++) @(posedge clk_sys_in);
      cur = code;
      check("switching done", 16'h0000, 16'(osc_switching_out));
    end
    repeat (6) @(posedge clk_sys_in);
    osc_ready_in <= 1'b0;
    check("current source", 16'(cur), 16'(current_source_out));
    rd(oscdz_pkg::OFS_OSC, d);
    check("osc after switch", {1'b0, cur, 1'b0, code, 8'h00}, d);
    check("switch irq", 16'h0001, 16'(irq_out));
    wr(oscdz_pkg::OFS_ICLR, 16'h0003);
    repeat (2) @(posedge clk_sys_in);
    check("irq cleared", 16'h0000, 16'(irq_out));
    repeat (4) @(posedge clk_sys_in);
  endtask : do_switch

  task automatic test_switch;
    // The two PLL modes are always separated by a fast RC step.
    do_switch(3'h1);
    do_switch(3'h0);
    do_switch(3'h3);
    do_switch(3'h2);
    do_switch(3'h5);
    do_switch(3'h6);
    do_switch(3'h7);
    do_switch(3'h4);
    do_switch(3'h0);
  endtask : test_switch

  task automatic test_fail;
    logic [15:0] d;
    int i;
    clock_fail_in <= 1'b1;
    for (i = 0; i < 10 && trap_cnt == 0; i++) @(posedge clk_sys_in);
    rd(oscdz_pkg::OFS_OSC, d);
    check("fail flag set", 16'h0008, d);
    check("monitor trap", 16'h0001, 16'(trap_cnt));
    rd(oscdz_pkg::OFS_STAT, d);
    check("fail status", 16'h0001, d & 16'h0001);
    clock_fail_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    wr_osc(16'h0000);
    rd(oscdz_pkg::OFS_OSC, d);
    check("fail flag clear", 16'h0000, d);
    wr_osc(16'h0008);
    wr_osc(16'h0008);
    rd(oscdz_pkg::OFS_OSC, d);
    check("soft fail flag", 16'h0008, d);
    check("soft trap", 16'h0002, 16'(trap_cnt));
    wr_osc(16'h0000);
    wr(oscdz_pkg::OFS_ICLR, 16'h0003);
  endtask : test_fail

  // Code 000 with enable requested must leave the full rate in place.
  task automatic test_doze;
    logic [15:0] d;
    logic [15:0] v;
    int          t0;
    for (int c = 0; c < 8; c++) begin
      wr(oscdz_pkg::OFS_DIV, 16'((c << 12) | (1 << 11) | (c << 8) | 16'h0040));
      v = 16'((c << 12) | ((c != 0) << 11) | (c << 8) | 16'h0040);
      rd(oscdz_pkg::OFS_DIV, d);
      check("divisor", v, d);
      check("rc ratio", (c == 7) ? 16'h0100 : 16'(1 << c), 16'(rc_div_ratio_out));
      repeat (130) @(posedge clk_sys_in);
      #1 t0 = tick_cnt;
      repeat (128) @(posedge clk_sys_in);
      #1 check("cpu ticks", (c == 0) ? 16'h0080 : 16'(128 >> c), 16'(tick_cnt - t0));
    end
  endtask : test_doze

  task automatic irq_pulse;
    @(posedge clk_sys_in);
    irq_event_in <= 1'b1;
    @(posedge clk_sys_in);
    irq_event_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask : irq_pulse

  task automatic test_recover;
    logic [15:0] d;
    wr(oscdz_pkg::OFS_DIV, 16'h1840);
    irq_pulse();
    rd(oscdz_pkg::OFS_DIV, d);
    check("no recover", 16'h1840, d);
    wr(oscdz_pkg::OFS_DIV, 16'h9840);
    irq_pulse();
    rd(oscdz_pkg::OFS_DIV, d);
    check("recover", 16'h9040, d);
  endtask : test_recover

  // Clock enable low freezes every register, so a write in that time is lost.
  task automatic test_hold;
    logic [15:0] d;
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    wr(oscdz_pkg::OFS_DIV, 16'h0040);
    ce_in <= 1'b1;
    rd(oscdz_pkg::OFS_DIV, d);
    check("frozen divisor", 16'h9040, d);
  endtask : test_hold

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    test_reset();
    wr(oscdz_pkg::OFS_IEN, 16'h0003);
    test_lock();
    test_switch();
    test_fail();
    test_doze();
    test_recover();
    test_hold();
    finish_test();
  end
endmodule : oscdz_top_bench
`default_nettype wire
